/* File: include/bcd_pkg.sv */
// constants and types shared by the bit and control operation decoder
`default_nettype none
package bcd_pkg;

	localparam int          PC_W          = 20;

	// top nibble of the instruction word
	localparam logic [3:0]  OPN_BIT_TOG   = 4'h7;
	localparam logic [3:0]  OPN_BIT_SET   = 4'h8;
	localparam logic [3:0]  OPN_BIT_CLR   = 4'h9;
	localparam logic [3:0]  OPN_SKIP_SET  = 4'hA;
	localparam logic [3:0]  OPN_SKIP_CLR  = 4'hB;
	localparam logic [3:0]  OPN_REL       = 4'hD;
	localparam logic [3:0]  OPN_LONG      = 4'hE;
	localparam logic [3:0]  OPN_SECOND    = 4'hF;

	// upper five, seven and eight bit forms
	localparam logic [6:0]  HI7_CALL      = 7'h76;
	localparam logic [7:0]  HI8_JUMP      = 8'hEF;
	localparam logic [7:0]  HI8_RET_LIT   = 8'h0C;
	localparam logic [4:0]  HI5_COND      = 5'h1C;

	// whole-word and upper fifteen bit forms
	localparam logic [15:0] W_SLEEP       = 16'h0003;
	localparam logic [15:0] W_WDT_CLR     = 16'h0004;
	localparam logic [15:0] W_PUSH        = 16'h0005;
	localparam logic [15:0] W_POP         = 16'h0006;
	localparam logic [15:0] W_SOFT_RESET  = 16'h00FF;
	localparam logic [14:0] W15_INT_RET   = 15'h0008;
	localparam logic [14:0] W15_SUB_RET   = 15'h0009;

	// condition selector, bit 8 inverts
	localparam logic [1:0]  CND_ZERO      = 2'h0;
	localparam logic [1:0]  CND_CARRY     = 2'h1;
	localparam logic [1:0]  CND_OVF       = 2'h2;

	// values after reset
	localparam logic [19:0] PC_RST        = 20'h00000;
	localparam logic        TIMEOUT_RST   = 1'b1;
	localparam logic        PWRDOWN_RST   = 1'b1;

	typedef enum logic [1:0] {
		ST_EXEC,
		ST_SECOND,
		ST_FLUSH,
		ST_SKIP
	} bcd_state_t;

	function automatic logic [7:0] bcd_mask(input logic [2:0] idx);
		bcd_mask = 8'h01 << idx;
	endfunction

	function automatic logic [19:0] bcd_rel(input logic [19:0] base,
		input logic [10:0] off);
		logic [19:0] ext;
		ext = {{9{off[10]}}, off};
		bcd_rel = base + 20'h00001 + ext;
	endfunction

endpackage

`default_nettype wire

/* File: core/bcd_decoder.sv */
// bit-oriented and control-flow instruction decoder and sequencer
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module bcd_decoder (
	input  wire logic                      clk_sys,
	input  wire logic                      sys_rst,
	input  wire logic [15:0]               instr_word,
	input  wire logic [7:0]                file_rd_data,
	input  wire logic                      file_is_port,
	input  wire logic [7:0]                port_pin_levels,
	input  wire logic                      file_is_timer_zero,
	input  wire logic                      prescaler_assigned,
	input  wire logic                      status_carry,
	input  wire logic                      status_zero,
	input  wire logic                      status_overflow,
	input  wire logic                      status_negative,
	input  wire logic [bcd_pkg::PC_W-1:0]  return_stack_top,
	input  wire logic                      watchdog_expired,
	output var  logic [bcd_pkg::PC_W-1:0]  prog_addr,
	output var  logic                      file_wr_en,
	output var  logic [7:0]                file_wr_addr,
	output var  logic                      file_wr_access,
	output var  logic [7:0]                file_wr_data,
	output var  logic                      prescaler_clear,
	output var  logic                      stack_push,
	output var  logic                      stack_pop,
	output var  logic [bcd_pkg::PC_W-1:0]  stack_push_value,
	output var  logic                      fast_save,
	output var  logic                      fast_restore,
	output var  logic                      working_wr_en,
	output var  logic [7:0]                working_wr_data,
	output var  logic                      global_irq_enable_set,
	output var  logic                      standby_req,
	output var  logic                      watchdog_clear_op,
	output var  logic                      soft_reset_req,
	output var  logic                      timeout_flag,
	output var  logic                      powerdown_flag
);
	import bcd_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// decode

	bcd_state_t   state;
	bcd_state_t   next_state;
	logic [19:0]  next_pc;
	logic [7:0]   long_lo;
	logic         long_call;
	logic         long_fast;
	logic         exec;
	logic [3:0]   op;
	logic [7:0]   bit_mask;
	logic [7:0]   operand;
	logic         bit_val;
	logic         skip_hit;
	logic         is_cond;
	logic         cond_true;
	logic         flag_sel;
	logic         is_call;
	logic         is_jump;
	logic         is_int_ret;
	logic         is_sub_ret;
	logic         is_lit_ret;
	logic         is_bit_wr;

	assign exec     = (state == ST_EXEC);
	assign op       = instr_word[15:12];
	assign bit_mask = bcd_mask(instr_word[11:9]);
	// port registers read back what the pins show, not the latch
	assign operand  = file_is_port ? port_pin_levels : file_rd_data;
	assign bit_val  = |(operand & bit_mask);
	assign skip_hit = (op == OPN_SKIP_CLR && !bit_val)
		|| (op == OPN_SKIP_SET && bit_val);

	assign is_cond    = (instr_word[15:11] == HI5_COND);
	assign is_call    = (instr_word[15:9] == HI7_CALL);
	assign is_jump    = (instr_word[15:8] == HI8_JUMP);
	assign is_int_ret = (instr_word[15:1] == W15_INT_RET);
	assign is_sub_ret = (instr_word[15:1] == W15_SUB_RET);
	assign is_lit_ret = (instr_word[15:8] == HI8_RET_LIT);
	assign is_bit_wr  = exec && (op == OPN_BIT_CLR || op == OPN_BIT_SET
		|| op == OPN_BIT_TOG);

	always_comb begin
		case (instr_word[10:9])
			CND_ZERO:  flag_sel = status_zero;
			CND_CARRY: flag_sel = status_carry;
			CND_OVF:   flag_sel = status_overflow;
			default:   flag_sel = status_negative;
		endcase
		cond_true = flag_sel ^ instr_word[8];
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer

	always_comb begin
		next_state = ST_EXEC;
		next_pc    = prog_addr + 20'h00001;
		case (state)
			ST_EXEC: begin
				if (op == OPN_SKIP_CLR || op == OPN_SKIP_SET) begin
					if (skip_hit) begin
						next_state = ST_SKIP;
					end
				end else if (op == OPN_REL) begin
					next_pc    = bcd_rel(prog_addr, instr_word[10:0]);
					next_state = ST_FLUSH;
				end else if (is_cond) begin
					if (cond_true) begin
						next_pc    = bcd_rel(prog_addr,
							{{3{instr_word[7]}}, instr_word[7:0]});
						next_state = ST_FLUSH;
					end
				end else if (is_call || is_jump) begin
					next_state = ST_SECOND;
				end else if (is_int_ret || is_sub_ret || is_lit_ret) begin
					next_pc    = return_stack_top;
					next_state = ST_FLUSH;
				end else if (instr_word == W_SOFT_RESET) begin
					next_pc    = PC_RST;
					next_state = ST_FLUSH;
				end
			end
			ST_SECOND: begin
				// the second word carries the upper twelve address bits
				next_pc = {instr_word[11:0], long_lo};
			end
			ST_FLUSH: begin
				// fetched word at the new address is replayed next cycle
				next_pc = prog_addr;
			end
			ST_SKIP: begin
				// a skipped first word leaves its second word to run idle
				next_pc = prog_addr + 20'h00001;
			end
			default: begin
				next_pc = prog_addr;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state     <= ST_EXEC;
			prog_addr <= PC_RST;
		end else begin
			state     <= next_state;
			prog_addr <= next_pc;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			long_lo   <= 8'h00;
			long_call <= 1'b0;
			long_fast <= 1'b0;
		end else if (exec) begin
			long_lo   <= instr_word[7:0];
			long_call <= is_call;
			long_fast <= instr_word[8];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// data memory write-back

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			file_wr_en      <= 1'b0;
			file_wr_addr    <= 8'h00;
			file_wr_access  <= 1'b0;
			file_wr_data    <= 8'h00;
			prescaler_clear <= 1'b0;
		end else begin
			file_wr_en      <= is_bit_wr;
			file_wr_addr    <= instr_word[7:0];
			file_wr_access  <= instr_word[8];
			case (op)
				OPN_BIT_CLR: file_wr_data <= operand & ~bit_mask;
				OPN_BIT_SET: file_wr_data <= operand | bit_mask;
				default:     file_wr_data <= operand ^ bit_mask;
			endcase
			prescaler_clear <= is_bit_wr && file_is_timer_zero
				&& prescaler_assigned;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// return stack and working register

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			stack_push       <= 1'b0;
			stack_pop        <= 1'b0;
			stack_push_value <= PC_RST;
			fast_save        <= 1'b0;
			fast_restore     <= 1'b0;
			working_wr_en    <= 1'b0;
			working_wr_data  <= 8'h00;
		end else begin
			// every push stores the address after the current word
			stack_push <= (exec && (instr_word == W_PUSH
				|| (op == OPN_REL && instr_word[11])))
				|| (state == ST_SECOND && long_call);
			stack_push_value <= prog_addr + 20'h00001;
			fast_save        <= state == ST_SECOND && long_call && long_fast;
			stack_pop <= exec && (instr_word == W_POP
				|| is_int_ret || is_sub_ret || is_lit_ret);
			fast_restore    <= exec && (is_int_ret || is_sub_ret)
				&& instr_word[0];
			working_wr_en   <= exec && is_lit_ret;
			working_wr_data <= instr_word[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// power and system control

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			global_irq_enable_set <= 1'b0;
			standby_req           <= 1'b0;
			watchdog_clear_op     <= 1'b0;
			soft_reset_req        <= 1'b0;
			timeout_flag          <= TIMEOUT_RST;
			powerdown_flag        <= PWRDOWN_RST;
		end else begin
			global_irq_enable_set <= exec && is_int_ret;
			standby_req           <= exec && instr_word == W_SLEEP;
			watchdog_clear_op     <= exec && instr_word == W_WDT_CLR;
			soft_reset_req        <= exec && instr_word == W_SOFT_RESET;
			// the instruction wins over a watchdog expiry in the same cycle
			if (exec && instr_word == W_SLEEP) begin
				timeout_flag   <= 1'b1;
				powerdown_flag <= 1'b0;
			end else if (exec && instr_word == W_WDT_CLR) begin
				timeout_flag   <= 1'b1;
				powerdown_flag <= 1'b1;
			end else if (watchdog_expired) begin
				timeout_flag <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	property p_skip_clr;
		@(posedge clk_sys) disable iff (sys_rst)
		exec && op == OPN_SKIP_CLR && !bit_val
			|=> state == ST_SKIP ##1 state == ST_EXEC;
	endproperty
	a_skip_clr: assert property (p_skip_clr)
		else $error("clear test did not skip");
	property p_skip_set;
		@(posedge clk_sys) disable iff (sys_rst)
		exec && op == OPN_SKIP_SET && !bit_val
			|=> state == ST_EXEC && prog_addr == $past(prog_addr) + 20'h00001;
	endproperty
	a_skip_set: assert property (p_skip_set)
		else $error("set test skipped on a zero bit");
	property p_call;
		@(posedge clk_sys) disable iff (sys_rst)
		exec && is_call |=> state == ST_SECOND ##1
			(stack_push && state == ST_EXEC);
	endproperty
	a_call: assert property (p_call)
		else $error("call did not push in its second cycle");
	property p_jump;
		@(posedge clk_sys) disable iff (sys_rst)
		(exec && is_jump) ##1 1'b1 |=>
			prog_addr == {$past(instr_word[11:0]), $past(instr_word[7:0], 2)};
	endproperty
	a_jump: assert property (p_jump)
		else $error("absolute jump reached the wrong address");
	property p_pop;
		@(posedge clk_sys) disable iff (sys_rst)
		exec && instr_word == W_POP |=> stack_pop && !stack_push
			&& prog_addr == $past(prog_addr) + 20'h00001;
	endproperty
	a_pop: assert property (p_pop)
		else $error("pop misbehaved");
	property p_push;
		@(posedge clk_sys) disable iff (sys_rst)
		exec && instr_word == W_PUSH |=> stack_push
			&& stack_push_value == prog_addr && state == ST_EXEC;
	endproperty
	a_push: assert property (p_push)
		else $error("push stored the wrong address");
	property p_int_ret;
		@(posedge clk_sys) disable iff (sys_rst)
		exec && is_int_ret |=> stack_pop && global_irq_enable_set
			&& prog_addr == $past(return_stack_top) ##1 state == ST_EXEC;
	endproperty
	a_int_ret: assert property (p_int_ret)
		else $error("interrupt return misbehaved");
	property p_lit_ret;
		@(posedge clk_sys) disable iff (sys_rst)
		exec && is_lit_ret |=> working_wr_en && stack_pop
			&& working_wr_data == $past(instr_word[7:0]);
	endproperty
	a_lit_ret: assert property (p_lit_ret)
		else $error("literal return lost its literal");
	property p_sleep;
		@(posedge clk_sys) disable iff (sys_rst)
		exec && instr_word == W_SLEEP |=> standby_req && timeout_flag
			&& !powerdown_flag;
	endproperty
	a_sleep: assert property (p_sleep)
		else $error("sleep flags wrong");
	property p_port_src;
		@(posedge clk_sys) disable iff (sys_rst)
		exec && op == OPN_BIT_TOG && file_is_port |=> file_wr_en
			&& file_wr_data == ($past(port_pin_levels) ^ $past(bit_mask));
	endproperty
	a_port_src: assert property (p_port_src)
		else $error("port write-back did not use pin levels");
	property p_prescaler;
		@(posedge clk_sys) disable iff (sys_rst)
		prescaler_clear == (file_wr_en && $past(file_is_timer_zero)
			&& $past(prescaler_assigned));
	endproperty
	a_prescaler: assert property (p_prescaler)
		else $error("prescaler clear did not follow a timer write");
	property p_flush_idle;
		@(posedge clk_sys) disable iff (sys_rst)
		state == ST_FLUSH || state == ST_SKIP |=> !file_wr_en && !stack_pop
			&& !working_wr_en && !standby_req;
	endproperty
	a_flush_idle: assert property (p_flush_idle)
		else $error("idle cycle had an effect");
	property p_bit_clr;
		@(posedge clk_sys) disable iff (sys_rst)
		exec && op == OPN_BIT_CLR |=> file_wr_en
			&& file_wr_data == ($past(operand) & ~$past(bit_mask));
	endproperty
	a_bit_clr: assert property (p_bit_clr)
		else $error("bit clear wrote the wrong byte");
	property p_cond_not;
		@(posedge clk_sys) disable iff (sys_rst)
		exec && is_cond && !cond_true |=> state == ST_EXEC
			&& prog_addr == $past(prog_addr) + 20'h00001;
	endproperty
	a_cond_not: assert property (p_cond_not)
		else $error("untaken branch cost a cycle");

endmodule

`default_nettype wire

/* File: testbench/bcd_prog_mem.sv */
// program memory partner: combinational word read, loaded by the bench
`timescale 1ns/1ps
`default_nettype none

module bcd_prog_mem (
	input  wire logic [bcd_pkg::PC_W-1:0] prog_addr,
	input  wire logic                     clk_sys,
	input  wire logic                     ld_en,
	input  wire logic [7:0]               ld_addr,
	input  wire logic [15:0]              ld_data,
	output var  logic [15:0]              instr_word
);
	import bcd_pkg::*;

	logic [15:0] mem [256];

	// cleared to no-ops so a runaway fetch never feeds unknowns
	initial begin
		for (int i = 0; i < 256; i++)
			mem[i] = 16'h0000;
	end

	// upper address bits alias: long targets land in the small array
	assign instr_word = mem[prog_addr[7:0]];

	always @(posedge clk_sys) begin
		if (ld_en)
			mem[ld_addr] <= ld_data;
	end
endmodule

`default_nettype wire

/* File: testbench/test_bit_and_control_op_decoder.sv */
// self-checking bench for the bit and control operation decoder
`timescale 1ns/1ps
`default_nettype none

module test_bit_and_control_op_decoder;
	import bcd_pkg::*;

	localparam logic [10:0] E_WR = 11'h400;
	localparam logic [10:0] E_PC = 11'h200;
	localparam logic [10:0] E_PU = 11'h100;
	localparam logic [10:0] E_PO = 11'h080;
	localparam logic [10:0] E_FS = 11'h040;
	localparam logic [10:0] E_FR = 11'h020;
	localparam logic [10:0] E_WW = 11'h010;
	localparam logic [10:0] E_IE = 11'h008;
	localparam logic [10:0] E_SB = 11'h004;
	localparam logic [10:0] E_WD = 11'h002;
	localparam logic [10:0] E_SR = 11'h001;

	logic        clk_sys, sys_rst, ld_en, file_is_port, file_is_timer_zero;
	logic        prescaler_assigned, watchdog_expired, run, tk, hit;
	logic        status_carry, status_zero, status_overflow, status_negative;
	logic [7:0]  ld_addr, file_rd_data, port_pin_levels, lit;
	logic [15:0] ld_data, instr_word;
	logic [19:0] return_stack_top, prog_addr, stack_push_value, pa, p, t;
	logic        file_wr_en, file_wr_access, prescaler_clear, stack_push;
	logic        stack_pop, fast_save, fast_restore, working_wr_en;
	logic        global_irq_enable_set, standby_req, watchdog_clear_op;
	logic        soft_reset_req, timeout_flag, powerdown_flag;
	logic [7:0]  file_wr_addr, file_wr_data, working_wr_data;
	logic [12:0] ob;
	logic [19:0] ov;
	logic [1:0]  fl;
	logic [2:0]  b;
	logic [3:0]  op, fg;
	logic [11:0] hi;
	logic [52:0] q [$];
	int          failures, tests_run;

	bcd_decoder u_bcd_decoder (
		.clk_sys, .sys_rst, .instr_word, .file_rd_data, .file_is_port,
		.port_pin_levels, .file_is_timer_zero, .prescaler_assigned,
		.status_carry, .status_zero, .status_overflow, .status_negative,
		.return_stack_top, .watchdog_expired, .prog_addr, .file_wr_en,
		.file_wr_addr, .file_wr_access, .file_wr_data, .prescaler_clear,
		.stack_push, .stack_pop, .stack_push_value, .fast_save,
		.fast_restore, .working_wr_en, .working_wr_data,
		.global_irq_enable_set, .standby_req, .watchdog_clear_op,
		.soft_reset_req, .timeout_flag, .powerdown_flag
	);

	bcd_prog_mem u_bcd_prog_mem (
		.prog_addr, .clk_sys, .ld_en, .ld_addr, .ld_data, .instr_word
	);

	////////////////////////////////////////////////////////////////////////
	assign ob = {file_wr_en, prescaler_clear, stack_push, stack_pop,
		fast_save, fast_restore, working_wr_en, global_irq_enable_set,
		standby_req, watchdog_clear_op, soft_reset_req, timeout_flag,
		powerdown_flag};
	// data outputs are only meaningful beside their own pulse
	assign ov = stack_push ? stack_push_value
		: file_wr_en ? {3'h0, file_wr_access, file_wr_addr, file_wr_data}
		: working_wr_en ? {12'h000, working_wr_data} : 20'h00000;

	initial begin
		clk_sys = 1'h0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [52:0] g, input logic [52:0] e);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// one note per clock cycle, oldest first
	always @(negedge clk_sys) begin
		if (run && q.size() > 0)
			chk({prog_addr, ob, ov}, q.pop_front());
	end

	task automatic en(input logic [19:0] pc, input logic [10:0] e,
		input logic [19:0] v);
		q.push_back({pc, e, fl, v});
	endtask

	task automatic put(input logic [15:0] w);
		@(posedge clk_sys);
		ld_en <= 1'h1;
		ld_addr <= pa[7:0];
		ld_data <= w;
		pa = pa + 20'h00001;
	endtask

	task automatic bop(input logic [3:0] o);
		logic [2:0] bi;
		logic       a;
		logic [7:0] f, s, m, r;
		bi = 3'($urandom);
		a = 1'($urandom);
		f = 8'($urandom);
		m = 8'h01 << bi;
		s = file_is_port ? port_pin_levels : file_rd_data;
		r = o == OPN_BIT_SET ? s | m : o == OPN_BIT_CLR ? s & ~m : s ^ m;
		en(pa + 20'h1, E_WR | (file_is_timer_zero && prescaler_assigned ?
			E_PC : 11'h0), {3'h0, a, f, r});
		put({o, bi, a, f});
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h3BC9));
		{sys_rst, run, ld_en, ld_addr, ld_data} = {1'h1, 26'h0};
		{file_is_port, file_is_timer_zero, prescaler_assigned} = 3'h0;
		{status_carry, status_zero, status_overflow, status_negative} = 4'h0;
		{file_rd_data, port_pin_levels, return_stack_top} = 36'h0;
		watchdog_expired = 1'h0;
		failures = 0;
		tests_run = 0;
		repeat (3) @(posedge clk_sys);
		for (int k = 0; k < 5; k++) begin
			@(posedge clk_sys);
			sys_rst <= 1'h1;
			file_is_port <= k[0];
			file_is_timer_zero <= k[1];
			prescaler_assigned <= 1'($urandom) | k[0];
			watchdog_expired <= (k == 3);
			file_rd_data <= 8'($urandom);
			port_pin_levels <= 8'($urandom);
			{status_carry, status_zero, status_overflow, status_negative}
				<= 4'($urandom);
			return_stack_top <= {12'($urandom), 8'hC0};
			@(posedge clk_sys);
			pa = 20'h0;
			// a standing expiry clears time-out on every cycle except the one after a sleep or watchdog clear
			fl = {!watchdog_expired, 1'h1};
			lit = 8'($urandom);
			bop(OPN_BIT_CLR);
			bop(OPN_BIT_SET);
			bop(OPN_BIT_TOG);
			en(pa + 20'h1, 11'h0, 20'h0);
			put(16'hF5A5);
			en(pa + 20'h1, E_PU, pa + 20'h1);
			put(W_PUSH);
			en(pa + 20'h1, E_PO, 20'h0);
			put(W_POP);
			fl = 2'h2;
			en(pa + 20'h1, E_SB, 20'h0);
			put(W_SLEEP);
			fl = 2'h3;
			en(pa + 20'h1, E_WD, 20'h0);
			put(W_WDT_CLR);
			fl = {!watchdog_expired, 1'h1};
			// skip tests read the register, so only without port aliasing
			if (!file_is_port) begin
				for (int j = 0; j < 4; j++) begin
					b = 3'($urandom);
					hit = file_rd_data[b];
					op = (j[1] ? hit : j[0]) ? OPN_SKIP_SET : OPN_SKIP_CLR;
					tk = (op == OPN_SKIP_SET) == hit;
					p = pa;
					put({op, b, 1'h0, 8'h10});
					en(p + 20'h1, 11'h0, 20'h0);
					if (j[1]) begin
						put({HI7_CALL, 1'h0, 8'h33});
						put({OPN_SECOND, 12'($urandom)});
						en(p + 20'h2, 11'h0, 20'h0);
						en(p + 20'h3, 11'h0, 20'h0);
					end else if (tk) begin
						put({OPN_BIT_SET, 4'h0, 8'h10});
						en(p + 20'h2, 11'h0, 20'h0);
					end else begin
						bop(OPN_BIT_SET);
					end
				end
			end
			fg = {status_negative, status_overflow, status_carry, status_zero};
			for (int c = 0; c < 8; c++) begin
				tk = fg[c[2:1]] != c[0];
				p = pa;
				put({HI5_COND, c[2:0], 8'h01});
				if (tk) begin
					en(p + 20'h2, 11'h0, 20'h0);
					en(p + 20'h2, 11'h0, 20'h0);
					put({OPN_BIT_SET, 4'h0, 8'h10});
				end else begin
					en(p + 20'h1, 11'h0, 20'h0);
					bop(OPN_BIT_SET);
				end
			end
			for (int r = 0; r < 2; r++) begin
				p = pa;
				put({OPN_REL, r[0], 11'h001});
				put(16'hF000);
				en(p + 20'h2, r ? E_PU : 11'h0, r ? p + 20'h1 : 20'h0);
				en(p + 20'h2, 11'h0, 20'h0);
			end
			for (int i = 0; i < 2; i++) begin
				p = pa;
				hi = 12'($urandom);
				t = {hi, p[7:0] + 8'h05};
				put(i ? {HI8_JUMP, t[7:0]} : {HI7_CALL, k[0], t[7:0]});
				put({OPN_SECOND, hi});
				en(p + 20'h1, 11'h0, 20'h0);
				en(t, i ? 11'h0 : E_PU | (k[0] ? E_FS : 11'h0),
					i ? 20'h0 : p + 20'h2);
				pa = t;
			end
			if (k < 2) begin
				put({W15_INT_RET, k[0]});
				en(return_stack_top, E_PO | E_IE | (k[0] ? E_FR : 11'h0),
					20'h0);
			end else if (k == 2) begin
				put({HI8_RET_LIT, lit});
				en(return_stack_top, E_PO | E_WW, {12'h0, lit});
			end else if (k == 3) begin
				put({W15_SUB_RET, 1'h1});
				en(return_stack_top, E_PO | E_FR, 20'h0);
			end else begin
				put(W_SOFT_RESET);
				en(20'h0, E_SR, 20'h0);
			end
			en(k == 4 ? 20'h0 : return_stack_top, 11'h0, 20'h0);
			@(posedge clk_sys);
			ld_en <= 1'h0;
			sys_rst <= 1'h0;
			@(posedge clk_sys);
			run = 1'h1;
			for (int i = 0; i < 300 && q.size() > 0; i++)
				@(posedge clk_sys);
			run = 1'h0;
			if (q.size() > 0) begin
				failures++;
				break;
			end
		end
		report_and_stop();
	end
endmodule

`default_nettype wire
